// ==== verilog/irc_defines.vh ====
// Constants for the infrared carrier generator: register map, field positions,
// reset values and division ratios.
// Assumes inclusion by bare name from the design files only.
`ifndef IRC_DEFINES_VH
`define IRC_DEFINES_VH

// The printed offset 0x6 is not a multiple of four, so it is kept as an index.
`define IRC_CTRL_INDEX        4'h6
`define IRC_CTRL_ADDR         12'h018
// Extra read-only status word holding the live carrier state.
`define IRC_STAT_INDEX        4'h7
`define IRC_STAT_ADDR         12'h01C

// Field positions inside the control register.
`define IRC_BIT_ENABLE        0
`define IRC_BIT_FREQ57        1
`define IRC_BIT_POLARITY      2
`define IRC_BIT_XTAL358       7

// Reset value of the control register.
`define IRC_CTRL_RESET        8'h00

// Oscillator pre-divide ratios.
`define IRC_PREDIV_RC_LOW     8'h04
`define IRC_PREDIV_RC_HIGH    8'h05
`define IRC_PREDIV_XTAL       8'h01

// Carrier division ratios.
`define IRC_DIV_57K_FULL      8'h40
`define IRC_DIV_38K_FULL      8'h60
`define IRC_DIV_57K_455K      8'h08
`define IRC_DIV_38K_455K      8'h0C

`endif

// ==== verilog/irc_divider.v ====
// Programmable divide-by-N counter producing a one-cycle tick every N input ticks.
// Assumes a single clock and an active-low asynchronous reset.
`default_nettype none

module irc_divider #(
   parameter WIDTH = 8                       // Counter width.
) (
   input  wire             clk_in,           // System clock.
   input  wire             reset_n_in,       // Asynchronous reset, active low.
   input  wire             restart_in,       // Synchronous restart of the count.
   input  wire             tick_in,          // Count enable pulse.
   input  wire [WIDTH-1:0] ratio_in,         // Division ratio, at least one.
   output reg              tick_out,         // One-cycle pulse every ratio ticks.
   output reg  [WIDTH-1:0] count_out         // Current count, for half-point compare.
);

   // Counts input ticks and wraps at the ratio; a ratio change takes effect at the next input tick.
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         count_out <= {WIDTH{1'b0}};
         tick_out  <= 1'b0;
      end else if (restart_in) begin
         // Restart puts the phase back to zero so the first period is whole.
         count_out <= {WIDTH{1'b0}};
         tick_out  <= 1'b0;
      end else if (tick_in) begin
         if (count_out >= ratio_in - {{(WIDTH-1){1'b0}}, 1'b1}) begin
            count_out <= {WIDTH{1'b0}};
            tick_out  <= 1'b1;
         end else begin
            count_out <= count_out + {{(WIDTH-1){1'b0}}, 1'b1};
            tick_out  <= 1'b0;
         end
      end else begin
         tick_out <= 1'b0;
      end
   end

endmodule // irc_divider

`default_nettype wire

// ==== verilog/irc_carrier_top.v ====
// Infrared carrier generator with an APB slave holding its control register.
// Assumes clk_in is the high oscillator clock; oscillator mode arrives as static inputs.
//
// Our own choice: the APB interface to the registers.
`default_nettype none
`include "irc_defines.vh"

module irc_carrier_top (
   input  wire        clk_in,                 // High oscillator clock.
   input  wire        reset_n_in,             // Asynchronous chip reset, active low.
   input  wire        psel_in,                // APB select.
   input  wire        penable_in,             // APB enable.
   input  wire        pwrite_in,              // APB direction, high for write.
   input  wire [11:0] paddr_in,               // APB byte address.
   input  wire [31:0] pwdata_in,              // APB write data.
   input  wire [3:0]  pstrb_in,               // APB byte strobes.
   output reg  [31:0] prdata_out,             // APB read data.
   output reg         pready_out,             // APB ready.
   output reg         pslverr_out,            // APB error for unmapped addresses.
   input  wire        internal_rc_oscillator_in, // High when the internal RC is the oscillator.
   input  wire        rc_high_range_in,       // High for the 19.2 or 20.8 MHz RC settings.
   input  wire        pin_data_in,            // Data written to the IR I/O pin.
   output reg         ir_out,                 // Gated carrier toward the emitter.
   output reg         ir_oe_out               // High while the block drives the pin.
);

   // Control register and derived fields.
   reg  [7:0] carrier_control_reg;            // Write-only control byte.
   reg  [7:0] carrier_control_next;           // Its next value.
   wire       carrier_output_enable   = carrier_control_reg[`IRC_BIT_ENABLE];
   wire       carrier_freq_select     = carrier_control_reg[`IRC_BIT_FREQ57];
   wire       carrier_polarity_select = carrier_control_reg[`IRC_BIT_POLARITY];
   wire       crystal_type_select     = carrier_control_reg[`IRC_BIT_XTAL358];

   // Carrier generation state.
   reg        enable_d_reg;                   // Enable of the previous cycle.
   reg  [7:0] prediv_ratio;                   // Selected oscillator pre-divide.
   reg  [7:0] carrier_ratio;                  // Selected carrier division ratio.
   reg        carrier_reg;                    // Square wave before gating.
   reg        carrier_next;                   // Its next value.
   wire       restart;                        // Restart both counters.
   wire       pre_tick;                       // Pre-divider output pulse.
   wire       car_tick;                       // Carrier period pulse.
   wire [7:0] pre_count;                      // Pre-divider phase, unused beyond the tick.
   wire [7:0] car_count;                      // Carrier phase used for duty.
   wire       data_active;                    // Pin data in the emitting state.

   // APB state machine, one-hot.
   localparam [2:0] ST_IDLE   = 3'b001;      // Waiting for a setup phase.
   localparam [2:0] ST_ACCESS = 3'b010;      // Answer being given this cycle.
   localparam [2:0] ST_DONE   = 3'b100;      // Transfer finished, ready drops.
   reg  [2:0] state_reg;                      // Current bus state.
   reg  [2:0] state_next;                     // Next bus state.
   reg [31:0] prdata_next;                    // Next read data.
   reg        pready_next;                    // Next ready.
   reg        pslverr_next;                   // Next error flag.
   wire       addr_ctrl = (paddr_in == `IRC_CTRL_ADDR);  // Control word hit.
   wire       addr_stat = (paddr_in == `IRC_STAT_ADDR);  // Status word hit.

   // Bus decode: ready is registered from the setup phase, so no access takes a wait state.
   always @* begin
      state_next           = state_reg;
      carrier_control_next = carrier_control_reg;
      prdata_next          = 32'h00000000;
      pready_next          = 1'b0;
      pslverr_next         = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            // Setup phase seen: answer in the following cycle.
            if (psel_in && !penable_in) begin
               state_next  = ST_ACCESS;
               pready_next = 1'b1;
               if (!addr_ctrl && !addr_stat) begin
                  pslverr_next = 1'b1;
               end else if (addr_stat && !pwrite_in) begin
                  prdata_next = {29'h00000000, ir_out, carrier_reg, carrier_output_enable};
               end
            end
         end
         ST_ACCESS: begin
            // Write takes effect at the edge that samples ready high.
            if (psel_in && penable_in && pwrite_in && addr_ctrl && pstrb_in[0]) begin
               carrier_control_next = {pwdata_in[`IRC_BIT_XTAL358], 4'h0,
                                       pwdata_in[`IRC_BIT_POLARITY:`IRC_BIT_ENABLE]};
            end
            state_next = ST_DONE;
         end
         ST_DONE: begin
            // A back-to-back setup phase is caught here as well.
            if (psel_in && !penable_in) begin
               state_next  = ST_ACCESS;
               pready_next = 1'b1;
               if (!addr_ctrl && !addr_stat) begin
                  pslverr_next = 1'b1;
               end else if (addr_stat && !pwrite_in) begin
                  prdata_next = {29'h00000000, ir_out, carrier_reg, carrier_output_enable};
               end
            end else begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // Bus registers. The control word is write-only, so a read of it returns zero.
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg           <= ST_IDLE;
         carrier_control_reg <= `IRC_CTRL_RESET;
         prdata_out          <= 32'h00000000;
         pready_out          <= 1'b0;
         pslverr_out         <= 1'b0;
      end else begin
         state_reg           <= state_next;
         carrier_control_reg <= carrier_control_next;
         prdata_out          <= prdata_next;
         pready_out          <= pready_next;
         pslverr_out         <= pslverr_next;
      end
   end

   // Ratio selection from oscillator mode and crystal type.
   always @* begin
      if (internal_rc_oscillator_in) begin
         // Crystal type is not consulted at all here.
         prediv_ratio  = rc_high_range_in ? `IRC_PREDIV_RC_HIGH
                                          : `IRC_PREDIV_RC_LOW;
         carrier_ratio = carrier_freq_select ? `IRC_DIV_57K_FULL
                                             : `IRC_DIV_38K_FULL;
      end else if (crystal_type_select) begin
         // A 3.58 MHz crystal feeds the carrier divider directly.
         prediv_ratio  = `IRC_PREDIV_XTAL;
         carrier_ratio = carrier_freq_select ? `IRC_DIV_57K_FULL
                                             : `IRC_DIV_38K_FULL;
      end else begin
         prediv_ratio  = `IRC_PREDIV_XTAL;
         carrier_ratio = carrier_freq_select ? `IRC_DIV_57K_455K
                                             : `IRC_DIV_38K_455K;
      end
   end

   // Restart on a rising enable and hold the counters while disabled.
   assign restart = !carrier_output_enable ||
                    (carrier_output_enable && !enable_d_reg);

   // Pre-divider, counting every oscillator clock; nothing else may clock it.
   irc_divider #(
      .WIDTH      (8)
   ) u_prediv (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .restart_in (restart),
      .tick_in    (1'b1),
      .ratio_in   (prediv_ratio),
      .tick_out   (pre_tick),
      .count_out  (pre_count)
   );

   // Carrier divider, counting pre-divider ticks.
   irc_divider #(
      .WIDTH      (8)
   ) u_cardiv (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .restart_in (restart),
      .tick_in    (pre_tick),
      .ratio_in   (carrier_ratio),
      .tick_out   (car_tick),
      .count_out  (car_count)
   );

   // High for the first half of the period; even ratios give exactly half duty.
   always @* begin
      carrier_next = (car_count < {1'b0, carrier_ratio[7:1]});
   end

   // Pin data polarity: polarity one emits while the data is low.
   assign data_active = carrier_polarity_select ? !pin_data_in : pin_data_in;

   // Output stage. The pin is driven only while enabled, so the port stays usable as I/O.
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         enable_d_reg <= 1'b0;
         carrier_reg  <= 1'b0;
         ir_out       <= 1'b0;
         ir_oe_out    <= 1'b0;
      end else begin
         enable_d_reg <= carrier_output_enable;
         carrier_reg  <= carrier_output_enable && carrier_next;
         ir_out       <= carrier_output_enable && carrier_reg && data_active;
         ir_oe_out    <= carrier_output_enable;
      end
   end

endmodule // irc_carrier_top

`default_nettype wire

// ==== tb/irc_emitter_model.sv ====
// Emitter on the IR pin: measures the carrier period and high time it receives.
// Assumes ir_in is sampled on the same clock that launches it.
`default_nettype none
module irc_emitter_model (
   input  wire logic clk_in,     // Sampling clock.
   input  wire logic ir_in,      // Gated carrier from the block.
   output var  int   period_out, // Cycles between the last two rises.
   output var  int   high_out,   // Cycles of the last high pulse.
   output var  int   edges_out   // Count of rises seen.
);
   timeunit 1ns;
   timeprecision 1ps;
   int   cnt  = 0;    // Cycles since the last rise.
   logic last = 1'b0; // Previous pin level.
   initial period_out = 0;
   initial high_out = 0;
   initial edges_out = 0;
   // The emitter only sees levels, so both edges are found by comparison.
   always @(posedge clk_in) begin
      last <= ir_in;
      cnt <= cnt + 1;
      if (ir_in && !last) begin
         period_out <= cnt + 1;
         edges_out <= edges_out + 1;
         cnt <= 0;
      end
      if (!ir_in && last) begin
         high_out <= cnt + 1;
      end
   end
endmodule // irc_emitter_model
`default_nettype wire

// ==== tb/irc_carrier_chk.sv ====
// Checker for the carrier block: bus timing, error flag and pin gating.
// Assumes binding to irc_carrier_top.
`default_nettype none
module irc_carrier_chk (
   input wire logic        clk_in,      // Clock.
   input wire logic        reset_n_in,  // Reset, active low.
   input wire logic        psel_in,     // Select.
   input wire logic        penable_in,  // Enable.
   input wire logic        pwrite_in,   // Direction.
   input wire logic [11:0] paddr_in,    // Address.
   input wire logic [31:0] prdata_out,  // Read data.
   input wire logic        pready_out,  // Ready.
   input wire logic        pslverr_out, // Error.
   input wire logic        ir_out,      // Gated carrier.
   input wire logic        ir_oe_out    // Pin drive enable.
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   logic [15:0] hi_run; // Length of the current high pulse.
   // Counts high cycles; the longest legal half period is 5 * 96 / 2.
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) hi_run <= 16'h0000;
      else hi_run <= ir_out ? hi_run + 16'h0001 : 16'h0000;
   end
   sequence s_setup; psel_in && !penable_in; endsequence
   sequence s_access; psel_in && penable_in; endsequence
   property p_ready_next; s_setup ##1 s_access |-> pready_out; endproperty
   a_ready_next: assert property (p_ready_next) else $error("ready missing in access");
   property p_ready_pulse; pready_out |=> !pready_out; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
   property p_ready_cause; pready_out |-> $past(psel_in && !penable_in); endproperty
   a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
   property p_err_ready; pslverr_out |-> pready_out; endproperty
   a_err_ready: assert property (p_err_ready) else $error("error flag without ready");
   property p_err_map;
      pready_out |-> pslverr_out == (paddr_in != 12'h018 && paddr_in != 12'h01C);
   endproperty
   a_err_map: assert property (p_err_map) else $error("error flag wrong for address");
   property p_wo_read; pready_out && !pwrite_in && paddr_in == 12'h018 |-> prdata_out == 32'h0; endproperty
   a_wo_read: assert property (p_wo_read) else $error("control register readable");
   property p_off_quiet; !ir_oe_out [*4] |-> !ir_out; endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("carrier while disabled");
   property p_high_bound; hi_run <= 16'h00F0; endproperty
   a_high_bound: assert property (p_high_bound) else $error("carrier high too long");
endmodule // irc_carrier_chk
bind irc_carrier_top irc_carrier_chk irc_carrier_chk_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
   .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
   .ir_out(ir_out), .ir_oe_out(ir_oe_out));
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench: APB writes and the static oscillator inputs set the mode, the emitter model measures the carrier.
// Assumes the emitter model and the checker are compiled before it.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_n, psel, penable, pwrite;   // Clock, reset and bus controls.
   logic [11:0] paddr;                                // Bus address.
   logic [31:0] pwdata, prdata, rdata;                // Bus data and last read.
   logic        pready, pslverr, rerr, ir, ir_oe;     // Bus answer and pin.
   logic        rc_osc, rc_high, pin_data;            // Static mode inputs.
   int          period, high, edges, e0, m, f, exp_p, num_errors = 0, samples_checked = 0;
   irc_carrier_top irc_carrier_top_inst (.clk_in(clk), .reset_n_in(rst_n), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .pstrb_in(4'hF), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .internal_rc_oscillator_in(rc_osc), .rc_high_range_in(rc_high), .pin_data_in(pin_data),
      .ir_out(ir), .ir_oe_out(ir_oe));
   irc_emitter_model irc_emitter_model_inst (.clk_in(clk), .ir_in(ir), .period_out(period),
      .high_out(high), .edges_out(edges));
   always #2.5 clk = ~clk;
   // One transfer; the request is held until ready is seen, then released for a cycle.
   task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int k;
      k = 0;
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h000000, d};
      @(posedge clk) penable <= 1'b1;
      do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 50);
      // A slave that never answers counts as a mismatch.
      if (k >= 50) num_errors++;
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk);
   endtask
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin num_errors++; $display("MISMATCH %s expected %h seen %h", nm, exp, got); end
   endtask
   // Waits for n more carrier rises, bounded so a dead carrier cannot hang the run.
   task wait_edges(input int n);
      int k;
      k = 0;
      e0 = edges;
      while (edges < e0 + n && k < 3000) begin @(posedge clk); k++; end
      chk("carrier rises", k < 3000, 1);
   endtask
   task print_verdict;
      $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
      pwdata = 32'h0; rc_osc = 1'b1; rc_high = 1'b0; pin_data = 1'b1;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("oe after reset", ir_oe, 0);
      // Modes: RC low, RC high, 3.58M crystal, 455k crystal; RC modes select 455k to prove it ignored.
      for (m = 0; m < 4; m++) for (f = 0; f < 2; f++) begin
         rc_osc <= (m < 2); rc_high <= (m == 1);
         apb(1'b1, 12'h018, {m == 2, 4'h0, 1'b0, f[0], 1'b1});
         wait_edges(3);
         exp_p = (m == 0 ? 4 : m == 1 ? 5 : 1) * (m == 3 ? (f ? 8 : 12) : (f ? 64 : 96));
         chk("period", period, exp_p);
         chk("high time", high * 2, period);
      end
      apb(1'b0, 12'h01C, 8'h00);
      chk("status enable", rdata[0], 1);
      apb(1'b0, 12'h018, 8'h00);
      chk("control read", rdata, 0);
      apb(1'b0, 12'h020, 8'h00);
      chk("unmapped error", rerr, 1);
      apb(1'b1, 12'h018, 8'h07); // 455k crystal, 57k, inverted polarity.
      repeat (4) @(posedge clk);
      e0 = edges;
      repeat (40) @(posedge clk);
      chk("no carrier on data one", edges - e0, 0);
      pin_data <= 1'b0;
      // The first rise may fall mid-phase, so the period is taken between later rises.
      wait_edges(3);
      chk("carrier on data zero", period, 8);
      apb(1'b1, 12'h018, 8'h00);
      repeat (4) @(posedge clk);
      e0 = edges;
      repeat (40) @(posedge clk);
      chk("disabled rises", edges - e0, 0);
      chk("disabled oe", ir_oe, 0);
      pin_data <= 1'b1;
      apb(1'b1, 12'h018, 8'h83);
      repeat (6) @(posedge clk);
      chk("restart high", ir, 1);
      chk("enabled oe", ir_oe, 1);
      print_verdict;
   end
   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      print_verdict;
   end
endmodule // testbench
`default_nettype wire
